/* caf_acceptance_filter.sv */
// Chosen here: the APB interface to the registers.
`include "caf_defines.svh"
`default_nettype none

// Operation
// - Every frame buffered; only accepted ones copied to foreground
// - Code and mask applied to identifier bytes
// - In the 32-bit layout extended uses four pairs, standard two
// - Compare code bits, qualify with mask
// - Mask zero must match, one ignores
// - Code and mask writable only in soft reset
// - Control covers spare pins seven to two
// - Pull-up enable bit drives pull devices
// - Reduced-drive bit selects weak output
// - Data write latches, driven when output
// - Data read: latch if output, else pin
// - Bits one, zero read transmit, receive
// - Direction zero input, one output
// - Layout field selects filters or closed
// - Hit index updated on foreground copy
module caf_acceptance_filter #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Received frames from the protocol engine
  input  wire logic              rx_frame_valid,
  input  wire logic [31:0]       rx_frame_id,
  input  wire logic              rx_frame_ext,
  output logic                   rx_accepted,
  output logic                   irq,
  // Bus pins
  input  wire logic              bus_receive_pin,
  input  wire logic              bus_transmit_pin,
  // Spare pins
  input  wire logic [7:2]        spare_pin_in,
  output logic      [7:2]        spare_pin_out,
  output logic      [7:2]        spare_pin_oe,
  output logic                   spare_pin_pullup_enable,
  output logic                   spare_pin_reduced_drive
);

  // ============================================================
  // Elaboration check
  if (ADDR_W < 12) begin : g_addr_check
    $error("ADDR_W must be at least 12");
  end

  // ============================================================
  // Declarations
  caf_filt_if flt ();

  caf_pkg::caf_bank_t   code,        next_code;
  caf_pkg::caf_bank_t   mask,        next_mask;
  caf_pkg::caf_layout_t layout,      next_layout;
  caf_pkg::caf_hit_t    hit_idx,     next_hit_idx;
  logic                 soft_reset,  next_soft_reset;
  logic [1:0]           status,      next_status;
  logic [1:0]           irq_mask,    next_irq_mask;
  logic [31:0]          bg_id,       next_bg_id;
  logic                 bg_ext,      next_bg_ext;
  logic                 bg_pend,     next_bg_pend;
  logic [31:0]          fg_id,       next_fg_id;
  logic                 next_rx_accepted;
  logic                 next_irq;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;
  logic [7:2]           next_pin_out;
  logic [7:2]           next_pin_oe;
  logic                 next_pullup;
  logic                 next_reduced;
  logic [7:0]           sync_a;
  logic [7:0]           sync_b;
  logic [1:0]           set_vec;
  logic [9:0]           idx;
  logic [2:0]           bsel;
  logic                 setup;
  logic                 wr_en;
  logic                 mapped;
  logic                 is_code;
  logic                 is_mask;
  logic [31:0]          rd_val;
  logic [7:0]           pin_view;
  logic [7:2]           wd_pins;
  logic [1:0]           wd_ctl;
  logic [1:0]           bus_pins;

  // ============================================================
  // Filter comparator
  assign flt.code   = code;
  assign flt.mask   = mask;
  assign flt.layout = layout;
  assign flt.id     = bg_id;
  assign flt.ext    = bg_ext;

  caf_filter u_filter (
    .flt (flt.flt)
  );

  // ============================================================
  // Pin synchroniser, two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else if (clk_en) begin
      sync_a <= {spare_pin_in, bus_transmit_pin, bus_receive_pin};
      sync_b <= sync_a;
    end
  end

  // Port data view: latch for outputs, pin for inputs
  always_comb begin
    pin_view[7:2] = (spare_pin_oe & spare_pin_out) | (~spare_pin_oe & sync_b[7:2]);
    pin_view[1:0] = sync_b[1:0];
  end

  assign wd_pins  = pwdata[7:2];
  assign wd_ctl   = pwdata[1:0];
  assign bus_pins = sync_b[1:0];

  // ============================================================
  // APB phase and address decode
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & mapped;  // Unmapped writes never land
  assign idx   = paddr[11:2];

  always_comb begin
    mapped  = 1'b1;
    is_code = 1'b0;
    is_mask = 1'b0;
    bsel    = 3'h0;
    rd_val  = 32'h0000_0000;
    if ((paddr >> 12) != '0) begin
      mapped = 1'b0;
    end else if (idx >= `CAF_IDX_MASK0 && idx <= `CAF_IDX_MASK3) begin
      is_mask = 1'b1;
      bsel    = 3'(idx - `CAF_IDX_MASK0);
    end else if (idx >= `CAF_IDX_CODE0 && idx <= `CAF_IDX_CODE3) begin
      is_code = 1'b1;
      bsel    = 3'(idx - `CAF_IDX_CODE0);
    end else if (idx >= `CAF_IDX_CODE4 && idx <= `CAF_IDX_CODE7) begin
      is_code = 1'b1;
      bsel    = 3'(idx - `CAF_IDX_CODE0);
    end else if (idx >= `CAF_IDX_MASK4 && idx <= `CAF_IDX_MASK7) begin
      is_mask = 1'b1;
      bsel    = 3'(idx - `CAF_IDX_MASK4 + 10'h004);
    end else if (idx == `CAF_IDX_CTRL0) begin
      rd_val[`CAF_CTRL0_SOFT_RESET] = soft_reset;
    end else if (idx == `CAF_IDX_ACCEPT) begin
      rd_val[`CAF_ACC_LAYOUT_LSB +: 2] = layout;
      rd_val[`CAF_ACC_HIT_LSB +: 3]    = hit_idx;
    end else if (idx == `CAF_IDX_IRQ_STAT) begin
      rd_val[1:0] = status;
    end else if (idx == `CAF_IDX_IRQ_MASK) begin
      rd_val[1:0] = irq_mask;
    end else if (idx == `CAF_IDX_FG_ID) begin
      rd_val = fg_id;
    end else if (idx == `CAF_IDX_PIN_CTL) begin
      rd_val[`CAF_PIN_CTL_PULLUP]  = spare_pin_pullup_enable;
      rd_val[`CAF_PIN_CTL_REDUCED] = spare_pin_reduced_drive;
    end else if (idx == `CAF_IDX_PIN_DATA) begin
      rd_val[7:0] = pin_view;
    end else if (idx == `CAF_IDX_PIN_DIR) begin
      rd_val[7:2] = spare_pin_oe;
    end else begin
      mapped = 1'b0;
    end
    if (is_code) begin
      rd_val[7:0] = code[bsel];
    end else if (is_mask) begin
      rd_val[7:0] = mask[bsel];
    end
  end

  // ============================================================
  // Filter bank, kept through reset
  always_comb begin
    next_code = code;
    next_mask = mask;
    if (wr_en && soft_reset && is_code) begin
      next_code[bsel] = pwdata[7:0];
    end
    if (wr_en && soft_reset && is_mask) begin
      next_mask[bsel] = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (clk_en) begin
      code <= next_code;
      mask <= next_mask;
    end
  end

  // ============================================================
  // Registers, receive path, interrupt and bus answer
  always_comb begin
    next_soft_reset  = soft_reset;
    next_layout      = layout;
    next_hit_idx     = hit_idx;
    next_irq_mask    = irq_mask;
    next_bg_id       = bg_id;
    next_bg_ext      = bg_ext;
    next_bg_pend     = 1'b0;
    next_fg_id       = fg_id;
    next_rx_accepted = 1'b0;
    next_pin_out     = spare_pin_out;
    next_pin_oe      = spare_pin_oe;
    next_pullup      = spare_pin_pullup_enable;
    next_reduced     = spare_pin_reduced_drive;
    set_vec          = 2'h0;
    // Judge the frame sitting in the background buffer
    if (bg_pend) begin
      if (flt.hit) begin
        next_fg_id                = bg_id;
        next_hit_idx              = flt.hit_idx;
        next_rx_accepted          = 1'b1;
        set_vec[`CAF_IRQ_ACCEPT]  = 1'b1;
      end else begin
        set_vec[`CAF_IRQ_DROP]    = 1'b1;
      end
    end
    // Every new frame overwrites the background buffer
    if (rx_frame_valid) begin
      next_bg_id   = rx_frame_id;
      next_bg_ext  = rx_frame_ext;
      next_bg_pend = 1'b1;
    end
    // Register writes
    if (wr_en) begin
      if (idx == `CAF_IDX_CTRL0) begin
        next_soft_reset = pwdata[`CAF_CTRL0_SOFT_RESET];
      end else if (idx == `CAF_IDX_ACCEPT && soft_reset) begin
        next_layout = caf_pkg::caf_layout_t'(pwdata[`CAF_ACC_LAYOUT_LSB +: 2]);
      end else if (idx == `CAF_IDX_IRQ_MASK) begin
        next_irq_mask = pwdata[1:0];
      end else if (idx == `CAF_IDX_PIN_CTL) begin
        next_pullup  = pwdata[`CAF_PIN_CTL_PULLUP];
        next_reduced = pwdata[`CAF_PIN_CTL_REDUCED];
      end else if (idx == `CAF_IDX_PIN_DATA) begin
        next_pin_out = pwdata[7:2];
      end else if (idx == `CAF_IDX_PIN_DIR) begin
        next_pin_oe = pwdata[7:2];
      end
    end
    // Sticky status, write one to clear, set wins
    next_status = status;
    if (wr_en && mapped && idx == `CAF_IDX_IRQ_STAT) begin
      next_status = status & ~pwdata[1:0];
    end
    next_status = next_status | set_vec;
    next_irq    = |(next_status & next_irq_mask);
    // Zero-wait answer in the first access cycle
    next_pready  = setup;
    next_pslverr = setup ? ~mapped : 1'b0;
    next_prdata  = (setup && !pwrite) ? rd_val : prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset              <= `CAF_RST_SOFT_RESET;
      layout                  <= caf_pkg::caf_layout_t'(`CAF_RST_LAYOUT);
      hit_idx                 <= `CAF_RST_HIT;
      status                  <= `CAF_RST_IRQ;
      irq_mask                <= `CAF_RST_IRQ;
      bg_id                   <= 32'h0000_0000;
      bg_ext                  <= 1'b0;
      bg_pend                 <= 1'b0;
      fg_id                   <= 32'h0000_0000;
      rx_accepted             <= 1'b0;
      irq                     <= 1'b0;
      prdata                  <= 32'h0000_0000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      spare_pin_out           <= `CAF_RST_PIN_BITS;
      spare_pin_oe            <= `CAF_RST_PIN_BITS;
      spare_pin_pullup_enable <= 1'(`CAF_RST_PIN_CTL >> `CAF_PIN_CTL_PULLUP);
      spare_pin_reduced_drive <= 1'(`CAF_RST_PIN_CTL >> `CAF_PIN_CTL_REDUCED);
    end else if (clk_en) begin
      soft_reset              <= next_soft_reset;
      layout                  <= next_layout;
      hit_idx                 <= next_hit_idx;
      status                  <= next_status;
      irq_mask                <= next_irq_mask;
      bg_id                   <= next_bg_id;
      bg_ext                  <= next_bg_ext;
      bg_pend                 <= next_bg_pend;
      fg_id                   <= next_fg_id;
      rx_accepted             <= next_rx_accepted;
      irq                     <= next_irq;
      prdata                  <= next_prdata;
      pready                  <= next_pready;
      pslverr                 <= next_pslverr;
      spare_pin_out           <= next_pin_out;
      spare_pin_oe            <= next_pin_oe;
      spare_pin_pullup_enable <= next_pullup;
      spare_pin_reduced_drive <= next_reduced;
    end
  end

  // ============================================================
  // Assertions
  close_no_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && bg_pend && layout == caf_pkg::caf_lay_closed) |=> !rx_accepted)
    else $error("closed filter accepted a frame");

  code_write_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && (is_code || is_mask) && !soft_reset) |=> ($stable(code) && $stable(mask)))
    else $error("filter bank changed outside soft reset");

  accept_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && bg_pend && flt.hit) |=> (rx_accepted && fg_id == $past(bg_id) && status[0]))
    else $error("accepted frame not copied or flagged");

  hit_index_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && bg_pend && flt.hit) |=> (hit_idx == $past(flt.hit_idx)))
    else $error("hit index not updated on copy");

  drop_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && bg_pend && !flt.hit) |=> (!rx_accepted && status[1] && fg_id == $past(fg_id)))
    else $error("rejected frame reached foreground");

  mask_free_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && bg_pend && layout == caf_pkg::caf_lay_8 && mask[0] == 8'hff) |=> (rx_accepted && hit_idx == 3'h0))
    else $error("fully masked filter did not hit");

  std_two_bytes_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && bg_pend && layout == caf_pkg::caf_lay_32 && !bg_ext &&
     mask[0] == 8'hff && mask[1] == 8'hff) |=> rx_accepted)
    else $error("standard frame judged on more than two bytes");

  dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && idx == `CAF_IDX_PIN_DIR) |=> (spare_pin_oe == $past(wd_pins)))
    else $error("direction write not applied");

  pin_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && wr_en && idx == `CAF_IDX_PIN_CTL) |=>
      ({spare_pin_pullup_enable, spare_pin_reduced_drive} == $past(wd_ctl)))
    else $error("pin control write not applied");

  bus_pin_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && setup && !pwrite && idx == `CAF_IDX_PIN_DATA && (paddr >> 12) == '0) |=>
      (pready && prdata[1:0] == $past(bus_pins)))
    else $error("bus pin levels not returned");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && |(set_vec & irq_mask)) |=> irq)
    else $error("unmasked event raised no interrupt");

endmodule : caf_acceptance_filter
`default_nettype wire

/* caf_acceptance_filter_notes_unused.sv */
`default_nettype none
`default_nettype wire

/* caf_defines.svh */
`ifndef CAF_DEFINES_SVH
`define CAF_DEFINES_SVH

// ============================================================
// Register indices (byte address = index * 4)
`define CAF_IDX_MASK0     10'h114
`define CAF_IDX_MASK1     10'h115
`define CAF_IDX_MASK2     10'h116
`define CAF_IDX_MASK3     10'h117
`define CAF_IDX_CODE0     10'h118
`define CAF_IDX_CODE1     10'h119
`define CAF_IDX_CODE2     10'h11a
`define CAF_IDX_CODE3     10'h11b
`define CAF_IDX_CODE4     10'h11c
`define CAF_IDX_CODE7     10'h11f
`define CAF_IDX_MASK4     10'h120
`define CAF_IDX_MASK7     10'h123
`define CAF_IDX_CTRL0     10'h100
`define CAF_IDX_ACCEPT    10'h10b
`define CAF_IDX_IRQ_STAT  10'h10c
`define CAF_IDX_IRQ_MASK  10'h10d
`define CAF_IDX_FG_ID     10'h10e
`define CAF_IDX_PIN_CTL   10'h13d
`define CAF_IDX_PIN_DATA  10'h13e
`define CAF_IDX_PIN_DIR   10'h13f

// ============================================================
// Field positions
`define CAF_CTRL0_SOFT_RESET   0
`define CAF_ACC_LAYOUT_LSB     4
`define CAF_ACC_HIT_LSB        0
`define CAF_IRQ_ACCEPT         0
`define CAF_IRQ_DROP           1
`define CAF_PIN_CTL_PULLUP     1
`define CAF_PIN_CTL_REDUCED    0

// ============================================================
// Reset values
`define CAF_RST_SOFT_RESET     1'b1
`define CAF_RST_LAYOUT         2'h0
`define CAF_RST_HIT            3'h0
`define CAF_RST_IRQ            2'h0
`define CAF_RST_PIN_CTL        2'h0
`define CAF_RST_PIN_BITS       6'h00

`endif

/* caf_filt_if.sv */
`default_nettype none
interface caf_filt_if;
  caf_pkg::caf_bank_t   code;
  caf_pkg::caf_bank_t   mask;
  caf_pkg::caf_layout_t layout;
  logic [31:0]          id;
  logic                 ext;
  logic                 hit;
  caf_pkg::caf_hit_t    hit_idx;

  // Owner of the bank and frame
  modport ctl (output code, mask, layout, id, ext, input hit, hit_idx);
  // Comparator
  modport flt (input code, mask, layout, id, ext, output hit, hit_idx);
endinterface : caf_filt_if
`default_nettype wire

/* caf_filter.sv */
`default_nettype none
module caf_filter (
  // Bank, frame and result
  caf_filt_if.flt flt
);

  // One byte passes when every unmasked bit agrees
  function automatic logic byte_ok(input logic [7:0] c, input logic [7:0] m, input logic [7:0] i);
    return &((c ~^ i) | m);
  endfunction : byte_ok

  logic [3:0][7:0] idb;

  // Identifier bytes, byte 0 first on the wire
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      idb[b] = flt.id[31 - 8*b -: 8];
    end
  end

  // Filters scanned high to low so the lowest index wins
  always_comb begin
    flt.hit     = 1'b0;
    flt.hit_idx = '0;
    case (flt.layout)
      caf_pkg::caf_lay_32: begin
        for (int k = 1; k >= 0; k--) begin
          if (byte_ok(flt.code[4*k], flt.mask[4*k], idb[0]) &&
              byte_ok(flt.code[4*k+1], flt.mask[4*k+1], idb[1]) &&
              (!flt.ext || (byte_ok(flt.code[4*k+2], flt.mask[4*k+2], idb[2]) &&
                            byte_ok(flt.code[4*k+3], flt.mask[4*k+3], idb[3])))) begin
            flt.hit     = 1'b1;
            flt.hit_idx = 3'(k);
          end
        end
      end
      caf_pkg::caf_lay_16: begin
        for (int k = 3; k >= 0; k--) begin
          if (byte_ok(flt.code[2*k], flt.mask[2*k], idb[0]) &&
              byte_ok(flt.code[2*k+1], flt.mask[2*k+1], idb[1])) begin
            flt.hit     = 1'b1;
            flt.hit_idx = 3'(k);
          end
        end
      end
      caf_pkg::caf_lay_8: begin
        for (int k = 7; k >= 0; k--) begin
          if (byte_ok(flt.code[k], flt.mask[k], idb[0])) begin
            flt.hit     = 1'b1;
            flt.hit_idx = 3'(k);
          end
        end
      end
      default: begin
        flt.hit = 1'b0;  // Closed filter accepts nothing
      end
    endcase
  end

endmodule : caf_filter
`default_nettype wire

/* caf_frame_src.sv */
`default_nettype none
// ============================================================
// Frame source in place of the protocol engine
module caf_frame_src (
  // Clock
  input  wire logic        pclk,
  // Frame strobe and identifier
  output var  logic        rx_frame_valid,
  output var  logic [31:0] rx_frame_id,
  output var  logic        rx_frame_ext
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet lines at time zero
  initial begin
    rx_frame_valid = 1'b0;
    rx_frame_id    = 32'h0;
    rx_frame_ext   = 1'b0;
  end

  // One-cycle strobe; idle lines then show the inverse, never a stale frame
  task automatic send(input logic [31:0] id, input logic ext);
    @(posedge pclk);
    rx_frame_valid <= 1'b1;
    rx_frame_id    <= id;
    rx_frame_ext   <= ext;
    @(posedge pclk);
    rx_frame_valid <= 1'b0;
    rx_frame_id    <= ~id;
    rx_frame_ext   <= ~ext;
  endtask : send
endmodule : caf_frame_src
`default_nettype wire

/* caf_pkg.sv */
`default_nettype none
package caf_pkg;
  // Filter layout selection
  typedef enum logic [1:0] {
    caf_lay_32     = 2'h0,
    caf_lay_16     = 2'h1,
    caf_lay_8      = 2'h2,
    caf_lay_closed = 2'h3
  } caf_layout_t;

  // Eight code or mask bytes
  typedef logic [7:0][7:0] caf_bank_t;
  // Index of the filter that hit
  typedef logic [2:0]      caf_hit_t;
endpackage : caf_pkg
`default_nettype wire

/* caf_tb.sv */
`include "caf_defines.svh"
`default_nettype none
// ============================================================
// Register-level bench
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, last_id, ex;
  logic        rerr, rx_accepted, irq, bus_receive_pin, bus_transmit_pin, pu, rd_en;
  logic        rx_frame_valid, rx_frame_ext;
  logic [31:0] rx_frame_id;
  logic [7:2]  spare_pin_in, spare_pin_out, spare_pin_oe;
  logic [9:0]  ci, mi;
  logic [2:0]  last_hit;
  logic [38:0] f;
  int          miscompares = 0, n_checks = 0, cycles = 0;
  // Code bytes 0..7 and mask bytes 0..7, byte 0 leftmost
  localparam logic [63:0] CODE = 64'h12345678_a5a5a5a5;
  localparam logic [63:0] MASK = 64'h00070007_00070f07;
  // Layout, extended, accepted, hit, identifier
  localparam logic [38:0] FR [10] = '{
    {2'h0, 1'b1, 1'b1, 3'h0, 32'h12345678}, {2'h0, 1'b1, 1'b0, 3'h0, 32'h12345778},
    {2'h0, 1'b0, 1'b1, 3'h0, 32'h1235ffff}, {2'h0, 1'b1, 1'b0, 3'h0, 32'h1235ffff},
    {2'h0, 1'b1, 1'b1, 3'h1, 32'ha5a5aaa5}, {2'h0, 1'b0, 1'b1, 3'h1, 32'ha5a50000},
    {2'h0, 1'b1, 1'b0, 3'h0, 32'h92345678}, {2'h1, 1'b0, 1'b1, 3'h1, 32'h567d0000},
    {2'h2, 1'b0, 1'b1, 3'h3, 32'h78000000}, {2'h3, 1'b1, 1'b0, 3'h0, 32'h12345678}};

  caf_frame_src u_src (.pclk(pclk), .rx_frame_valid(rx_frame_valid), .rx_frame_id(rx_frame_id),
    .rx_frame_ext(rx_frame_ext));

  caf_acceptance_filter DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_frame_valid(rx_frame_valid), .rx_frame_id(rx_frame_id),
    .rx_frame_ext(rx_frame_ext), .rx_accepted(rx_accepted), .irq(irq),
    .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin),
    .spare_pin_in(spare_pin_in), .spare_pin_out(spare_pin_out), .spare_pin_oe(spare_pin_oe),
    .spare_pin_pullup_enable(pu), .spare_pin_reduced_drive(rd_en));

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Verdict and end of run
  task automatic tally_and_finish;
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'(n < 50), 32'h1);
    @(posedge pclk);
  endtask : apb

  task automatic apb_wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : apb_wr

  task automatic apb_rd(input logic [9:0] idx, input logic [31:0] e, input string name);
    apb(1'b0, idx, 32'h0);
    chk(name, rdata, e);
  endtask : apb_rd

  // Clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en           = 1'b1;
    bus_receive_pin  = 1'b0;
    bus_transmit_pin = 1'b1;
    spare_pin_in     = 6'h15;
    last_hit         = 3'h0;
    last_id          = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("outs", 32'({spare_pin_oe, spare_pin_out, pu, rd_en, irq, rx_accepted}), 32'h0);
    apb_rd(`CAF_IDX_CTRL0, 32'h1, "ctrl0");
    apb_rd(`CAF_IDX_ACCEPT, 32'h0, "accept");
    apb_rd(`CAF_IDX_IRQ_STAT, 32'h0, "status");
    chk("slverr", 32'(rerr), 32'h0);
    apb_wr(10'h3ff, 32'hffffffff);
    chk("slverr", 32'(rerr), 32'h1);
    apb_rd(10'h3ff, 32'h0, "unmapped");
    chk("slverr", 32'(rerr), 32'h1);
    // Bank programming while in soft reset
    for (int i = 0; i < 8; i++) begin
      ci = (i < 4) ? 10'(`CAF_IDX_CODE0 + i) : 10'(`CAF_IDX_CODE4 + i - 4);
      mi = (i < 4) ? 10'(`CAF_IDX_MASK0 + i) : 10'(`CAF_IDX_MASK4 + i - 4);
      apb_wr(ci, 32'(CODE[63-8*i -: 8]));
      apb_wr(mi, 32'(MASK[63-8*i -: 8]));
      apb_rd(ci, 32'(CODE[63-8*i -: 8]), "code");
      apb_rd(mi, 32'(MASK[63-8*i -: 8]), "mask");
    end
    // Frames across all layouts; irq masked on the first
    for (int i = 0; i < 10; i++) begin
      f = FR[i];
      apb_wr(`CAF_IDX_ACCEPT, {26'h0, f[38:37], 4'h0});
      u_src.send(f[31:0], f[36]);
      repeat (2) @(posedge pclk);
      chk("accepted", 32'(rx_accepted), 32'(f[35]));
      if (f[35]) begin
        last_id  = f[31:0];
        last_hit = f[34:32];
      end
      apb_rd(`CAF_IDX_IRQ_STAT, f[35] ? 32'h1 : 32'h2, "status");
      chk("irq", 32'(irq), 32'(i > 0));
      apb_rd(`CAF_IDX_ACCEPT, {26'h0, f[38:37], 1'b0, last_hit}, "accept");
      apb_rd(`CAF_IDX_FG_ID, last_id, "fg_id");
      apb_wr(`CAF_IDX_IRQ_STAT, 32'h3);
      apb_wr(`CAF_IDX_IRQ_MASK, 32'h3);
      @(posedge pclk);
      chk("irq", 32'(irq), 32'h0);
    end
    // Fully masked filter 0 hits any identifier; a frozen clock takes no frame
    apb_wr(`CAF_IDX_MASK0, 32'hff);
    apb_wr(`CAF_IDX_MASK1, 32'hff);
    for (int j = 0; j < 3; j++) begin
      apb_wr(`CAF_IDX_ACCEPT, (j == 0) ? 32'h20 : 32'h0);
      clk_en <= (j < 2);
      u_src.send(32'h5a5a5a5a + j, 1'b0);
      repeat (2) @(posedge pclk);
      chk("masked", 32'(rx_accepted), 32'(j < 2));
    end
    clk_en <= 1'b1;
    apb_rd(`CAF_IDX_FG_ID, 32'h5a5a5a5b, "frozen_id");
    // Leave soft reset; bank and layout writes must be ignored
    apb_wr(`CAF_IDX_CTRL0, 32'h0);
    apb_wr(`CAF_IDX_CODE0, 32'hff);
    apb_wr(`CAF_IDX_MASK7, 32'hff);
    apb_wr(`CAF_IDX_ACCEPT, 32'h30);
    apb_rd(`CAF_IDX_CODE0, 32'h12, "code0");
    apb_rd(`CAF_IDX_MASK7, 32'h7, "mask7");
    apb_rd(`CAF_IDX_ACCEPT, 32'h0, "accept");
    // Mid-run reset keeps the bank and restores soft reset
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq_rst", 32'(irq), 32'h0);
    apb_rd(`CAF_IDX_CODE0, 32'h12, "code_kept");
    apb_rd(`CAF_IDX_CTRL0, 32'h1, "ctrl0_rst");
    // Pin drive controls
    for (int v = 0; v < 4; v++) begin
      apb_wr(`CAF_IDX_PIN_CTL, 32'(v));
      chk("pullup", 32'(pu), 32'(v[1]));
      chk("reduced", 32'(rd_en), 32'(v[0]));
      apb_rd(`CAF_IDX_PIN_CTL, 32'(v), "pin_ctl");
    end
    // Pins 7, 5, 3 out; latch written with bits 1:0 set too
    apb_wr(`CAF_IDX_PIN_DIR, 32'ha8);
    apb_wr(`CAF_IDX_PIN_DATA, 32'hcf);
    chk("oe", 32'(spare_pin_oe), 32'h2a);
    chk("out", 32'(spare_pin_out), 32'h33);
    for (int p = 0; p < 2; p++) begin
      spare_pin_in     <= p ? 6'h2a : 6'h15;
      bus_transmit_pin <= p == 0;
      bus_receive_pin  <= p == 1;
      repeat (3) @(posedge pclk);
      ex = 32'((8'hcc & 8'ha8) | ({spare_pin_in, 2'b00} & 8'h54) | {bus_transmit_pin, bus_receive_pin});
      apb_rd(`CAF_IDX_PIN_DATA, ex, "pin_data");
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
